// >>> safing_adc_pkg.sv
// ****************************************************************************
// safing converter sequencer: shared constants
// ****************************************************************************
// holds field positions, command codes, counts and reset values for the
// safing converter sequencer; assumes a 16-bit host serial frame.
package safing_adc_pkg;

   // ************************************************************************
   // serial frame layout
   // ************************************************************************
   localparam int unsigned FRAME_BITS    = 16;
   localparam int unsigned REQ_TYPE_BIT  = 13;
   localparam int unsigned SEQ_HI_BIT    = 15;
   localparam int unsigned SEQ_MID_BIT   = 14;
   localparam int unsigned SEQ_LO_BIT    = 12;
   localparam int unsigned CHAN_MSB      = 3;
   localparam int unsigned NO_DATA_BIT   = 4;
   localparam int unsigned NOT_CORR_BIT  = 3;
   localparam int unsigned OP_MSB        = 12;
   localparam int unsigned OP_LSB        = 8;
   localparam int unsigned ENABLE_BIT    = 0;
   localparam int unsigned REQ_ERR_BIT   = 8;

   localparam logic [3:0]  SAFING_CHANNEL   = 4'hf;
   localparam logic [4:0]  OP_RESERVE_TEST  = 5'h01;
   localparam logic [4:0]  OP_READ_DIAG     = 5'h02;
   localparam logic [1:0]  STAT_DATA        = 2'h1;
   localparam logic [1:0]  STAT_ERROR       = 2'h0;
   localparam logic [1:0]  NONSENSOR_KIND   = 2'h2;

   // ************************************************************************
   // converter, filter and self-test filter
   // ************************************************************************
   localparam int unsigned ADC_BITS      = 10;
   localparam int unsigned DIAG_BITS     = 8;
   localparam int unsigned FILT_SHIFT    = 6;
   localparam logic [2:0]  SUSPEND_SET_COUNT = 3'h3;
   localparam logic [2:0]  SUSPEND_CLR_COUNT = 3'h6;

   localparam logic [9:0]  SAMPLE_RESET  = 10'h000;
   localparam logic [7:0]  DIAG_RESET    = 8'h00;
   localparam logic [15:0] FIRST_RESPONSE = 16'h8100;
   localparam logic [9:0]  FILT_MIDSCALE = 10'h200;

   // conversion sequence
   typedef enum logic [1:0] {
      SEQ_IDLE     = 2'b00,
      SEQ_SAFING   = 2'b01,
      SEQ_RESERVE  = 2'b10
   } seq_state_t;

endpackage : safing_adc_pkg

// >>> safing_adc_sequencer.sv
// ****************************************************************************
// safing converter sequencer
// ****************************************************************************
// converter sequencing, drift removal, holding registers, self-test filter
// and host serial slave. assumes the converter runs on clk and answers
// each start with one done pulse; frame sync, self-test pin and serial
// pins are asynchronous.
`timescale 1ns/1ps

module safing_adc_sequencer #(
   parameter int unsigned FILT_SHIFT = safing_adc_pkg::FILT_SHIFT
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        clkEn,
   input  wire logic        frameSync,
   input  wire logic        selftestRequestPin,
   input  wire logic        convDone,
   input  wire logic [9:0]  convData,
   output logic             convStart,
   output logic             inputSelect,
   output logic             reserveDischarge,
   output logic             reserveTestEnable,
   output logic             safingSuspend,
   input  wire logic        csN,
   input  wire logic        sck,
   input  wire logic        si,
   output logic             so,
   output logic             soEn
);

   localparam int unsigned BASE_W = safing_adc_pkg::ADC_BITS + FILT_SHIFT;

   // ************************************************************************
   // state
   // ************************************************************************
   typedef struct packed {
      logic                        fsSync1;
      logic                        fsSync2;
      logic                        fsPrev;
      logic                        stSync1;
      logic                        stSync2;
      logic                        csSync1;
      logic                        csSync2;
      logic                        csPrev;
      logic                        sckSync1;
      logic                        sckSync2;
      logic                        sckPrev;
      logic                        siSync1;
      logic                        siSync2;
      safing_adc_pkg::seq_state_t  seq;
      logic                        convStart;
      logic                        inputSelect;
      logic                        discharge;
      logic                        sensorValid;
      logic                        reserveValid;
      logic [9:0]                  pendData;
      logic [BASE_W-1:0]           baseline;
      logic [9:0]                  sample;
      logic [7:0]                  diag;
      logic                        sampleRead;
      logic                        testEnable;
      logic                        suspend;
      logic [2:0]                  highCnt;
      logic [2:0]                  lowCnt;
      logic [15:0]                 rxShift;
      logic [4:0]                  bitCnt;
      logic [15:0]                 txShift;
      logic [15:0]                 respNext;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   logic   rstSync1_r;
   logic   rstN_r;

   // ************************************************************************
   // helpers
   // ************************************************************************
   // sensor response word, odd parity over all sixteen bits
   function automatic logic [15:0] sensorWord(input logic [2:0] sq,
                                              input logic [1:0] st,
                                              input logic [9:0] body);
      logic [15:0] w;
      w = {sq, 1'b0, st, body};
      w[12] = ~(^w);
      return w;
   endfunction : sensorWord

   // non-sensor response word with request error flag and data byte
   function automatic logic [15:0] nonSensorWord(input logic       reqErr,
                                                 input logic [7:0] data);
      logic [15:0] w;
      w = 16'h0000;
      w[15:14] = safing_adc_pkg::NONSENSOR_KIND;
      w[safing_adc_pkg::REQ_ERR_BIT] = reqErr;
      w[7:0] = data;
      return w;
   endfunction : nonSensorWord

   // ************************************************************************
   // reset release
   // ************************************************************************
   // reset enters asynchronously, is released through two flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rstSync1_r <= 1'b0;
         rstN_r     <= 1'b0;
      end else begin
         rstSync1_r <= 1'b1;
         rstN_r     <= rstSync1_r;
      end
   end

   // ************************************************************************
   // drift removal filter
   // ************************************************************************
   // baseline tracks slowly; output is sample minus baseline around midscale
   logic signed [BASE_W+1:0] filtDiff;
   logic signed [BASE_W+1:0] filtStep;
   logic signed [11:0]       filtCentered;
   logic [9:0]               filtOut;

   always_comb begin
      filtDiff = $signed({2'b00, s_r.pendData, {FILT_SHIFT{1'b0}}})
               - $signed({2'b00, s_r.baseline});
      filtStep = filtDiff >>> FILT_SHIFT;
      filtCentered = $signed({2'b00, s_r.pendData})
                   - $signed({2'b00, s_r.baseline[BASE_W-1:FILT_SHIFT]})
                   + $signed({2'b00, safing_adc_pkg::FILT_MIDSCALE});
      // saturate rather than wrap, a wrap would look like a crash pulse
      if (filtCentered < 0) begin
         filtOut = 10'h000;
      end else if (filtCentered > 12'sd1023) begin
         filtOut = 10'h3ff;
      end else begin
         filtOut = filtCentered[9:0];
      end
   end

   // ************************************************************************
   // next state
   // ************************************************************************
   logic        frameFall;
   logic        sckRise;
   logic        sckFall;
   logic        csFall;
   logic        csRise;
   logic [15:0] req;
   logic [2:0]  reqSeq;

   always_comb begin
      s_nxt = s_r;
      // two-flop synchronisers; only the second stage is looked at
      s_nxt.fsSync1  = frameSync;
      s_nxt.fsSync2  = s_r.fsSync1;
      s_nxt.fsPrev   = s_r.fsSync2;
      s_nxt.stSync1  = selftestRequestPin;
      s_nxt.stSync2  = s_r.stSync1;
      s_nxt.csSync1  = csN;
      s_nxt.csSync2  = s_r.csSync1;
      s_nxt.csPrev   = s_r.csSync2;
      s_nxt.sckSync1 = sck;
      s_nxt.sckSync2 = s_r.sckSync1;
      s_nxt.sckPrev  = s_r.sckSync2;
      s_nxt.siSync1  = si;
      s_nxt.siSync2  = s_r.siSync1;

      frameFall = s_r.fsPrev & ~s_r.fsSync2;
      sckRise   = ~s_r.sckPrev & s_r.sckSync2 & ~s_r.csSync2;
      sckFall   = s_r.sckPrev & ~s_r.sckSync2 & ~s_r.csSync2;
      csFall    = s_r.csPrev & ~s_r.csSync2;
      csRise    = ~s_r.csPrev & s_r.csSync2;
      req       = s_r.rxShift;
      reqSeq    = {req[safing_adc_pkg::SEQ_HI_BIT], req[safing_adc_pkg::SEQ_MID_BIT],
                   req[safing_adc_pkg::SEQ_LO_BIT]};

      s_nxt.convStart    = 1'b0;
      s_nxt.sensorValid  = 1'b0;
      s_nxt.reserveValid = 1'b0;

      // conversion sequence; a sync fall during a conversion is ignored
      case (s_r.seq)
         safing_adc_pkg::SEQ_IDLE: begin
            if (frameFall) begin
               s_nxt.seq         = safing_adc_pkg::SEQ_SAFING;
               s_nxt.convStart   = 1'b1;
               s_nxt.inputSelect = 1'b0;
               if (s_r.testEnable) begin
                  s_nxt.discharge = 1'b1;
               end
            end
         end
         safing_adc_pkg::SEQ_SAFING: begin
            if (convDone) begin
               s_nxt.pendData    = convData;
               s_nxt.sensorValid = ~s_r.suspend;
               s_nxt.inputSelect = 1'b1;
               s_nxt.convStart   = 1'b1;
               s_nxt.seq         = safing_adc_pkg::SEQ_RESERVE;
            end
         end
         safing_adc_pkg::SEQ_RESERVE: begin
            if (convDone) begin
               s_nxt.reserveValid = 1'b1;
               s_nxt.inputSelect  = 1'b0;
               if (s_r.testEnable) begin
                  s_nxt.discharge = 1'b0;
               end
               s_nxt.seq = safing_adc_pkg::SEQ_IDLE;
            end
         end
         default: begin
            s_nxt.seq = safing_adc_pkg::SEQ_IDLE;
         end
      endcase
      // with the test switched off the capacitor must not stay discharged
      if (!s_r.testEnable) begin
         s_nxt.discharge = 1'b0;
      end

      // filter and sample register take the held safing conversion
      if (s_r.sensorValid) begin
         s_nxt.baseline = s_r.baseline + filtStep[BASE_W-1:0];
         s_nxt.sample   = filtOut;
      end

      // self-test filter counts at each sync fall
      if (frameFall) begin
         if (s_r.stSync2) begin
            s_nxt.lowCnt = 3'h0;
            if (s_r.highCnt != safing_adc_pkg::SUSPEND_SET_COUNT) begin
               s_nxt.highCnt = s_r.highCnt + 3'h1;
            end
            if (s_r.highCnt + 3'h1 >= safing_adc_pkg::SUSPEND_SET_COUNT) begin
               s_nxt.suspend = 1'b1;
            end
         end else begin
            s_nxt.highCnt = 3'h0;
            if (s_r.lowCnt != safing_adc_pkg::SUSPEND_CLR_COUNT) begin
               s_nxt.lowCnt = s_r.lowCnt + 3'h1;
            end
            if (s_r.lowCnt + 3'h1 >= safing_adc_pkg::SUSPEND_CLR_COUNT) begin
               s_nxt.suspend = 1'b0;
            end
         end
         s_nxt.sampleRead = 1'b0;
      end

      // serial slave: capture on rising, shift out on falling
      if (csFall) begin
         s_nxt.bitCnt  = 5'h00;
         s_nxt.txShift = s_r.respNext;
      end
      if (sckRise) begin
         s_nxt.rxShift = {s_r.rxShift[14:0], s_r.siSync2};
         if (s_r.bitCnt != 5'h1f) begin
            s_nxt.bitCnt = s_r.bitCnt + 5'h01;
         end
      end
      if (sckFall) begin
         s_nxt.txShift = {s_r.txShift[14:0], 1'b0};
      end

      // request decode at frame end; short frames are dropped unanswered
      if (csRise && s_r.bitCnt == 5'(safing_adc_pkg::FRAME_BITS)) begin
         if (req[safing_adc_pkg::REQ_TYPE_BIT]) begin
            if (req[safing_adc_pkg::CHAN_MSB:0] == safing_adc_pkg::SAFING_CHANNEL) begin
               if (s_r.sampleRead) begin
                  s_nxt.respNext = sensorWord(reqSeq, safing_adc_pkg::STAT_ERROR,
                                              10'(1) << safing_adc_pkg::NO_DATA_BIT);
               end else begin
                  s_nxt.respNext   = sensorWord(reqSeq, safing_adc_pkg::STAT_DATA,
                                                s_r.sample);
                  s_nxt.sampleRead = 1'b1;
               end
            end else begin
               // satellite slots live elsewhere: answer not-correct
               s_nxt.respNext = sensorWord(reqSeq, safing_adc_pkg::STAT_ERROR,
                                           10'(1) << safing_adc_pkg::NOT_CORR_BIT);
            end
         end else if (req[safing_adc_pkg::OP_MSB:safing_adc_pkg::OP_LSB]
                      == safing_adc_pkg::OP_RESERVE_TEST) begin
            s_nxt.testEnable = req[safing_adc_pkg::ENABLE_BIT];
            s_nxt.respNext   = nonSensorWord(1'b0, {7'h00, req[safing_adc_pkg::ENABLE_BIT]});
         end else if (req[safing_adc_pkg::OP_MSB:safing_adc_pkg::OP_LSB]
                      == safing_adc_pkg::OP_READ_DIAG) begin
            s_nxt.respNext = nonSensorWord(1'b0, s_r.diag);
            s_nxt.diag     = safing_adc_pkg::DIAG_RESET;
         end else begin
            s_nxt.respNext = nonSensorWord(1'b1, 8'h00);
         end
      end

      // a new result wins over a read clear in the same cycle
      if (s_nxt.reserveValid) begin
         s_nxt.diag = convData[9:2];
      end
   end

   // ************************************************************************
   // registers
   // ************************************************************************
   // one register for all state but the reset release flops; clkEn low freezes it
   always_ff @(posedge clk or negedge rstN_r) begin
      if (!rstN_r) begin
         s_r             <= '0;
         s_r.fsSync1     <= 1'b1;
         s_r.fsSync2     <= 1'b1;
         s_r.fsPrev      <= 1'b1;
         s_r.csSync1     <= 1'b1;
         s_r.csSync2     <= 1'b1;
         s_r.csPrev      <= 1'b1;
         s_r.seq         <= safing_adc_pkg::SEQ_IDLE;
         s_r.sample      <= safing_adc_pkg::SAMPLE_RESET;
         s_r.diag        <= safing_adc_pkg::DIAG_RESET;
         s_r.suspend     <= 1'b0;
         s_r.respNext    <= safing_adc_pkg::FIRST_RESPONSE;
         s_r.txShift     <= safing_adc_pkg::FIRST_RESPONSE;
      end else if (clkEn) begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************************
   // outputs
   // ************************************************************************
   assign convStart         = s_r.convStart;
   assign inputSelect       = s_r.inputSelect;
   assign reserveDischarge  = s_r.discharge;
   assign reserveTestEnable = s_r.testEnable;
   assign safingSuspend     = s_r.suspend;
   assign so                = s_r.txShift[15];
   assign soEn              = ~s_r.csSync2;

   // ************************************************************************
   // checks
   // ************************************************************************
   a_start_on_sync: assert property (@(posedge clk) disable iff (!rstN_r)
      (clkEn && frameFall && s_r.seq == safing_adc_pkg::SEQ_IDLE)
      |=> (s_r.convStart && !s_r.inputSelect))
      else $error("no safing start after sync fall");

   a_strobe_follows: assert property (@(posedge clk) disable iff (!rstN_r)
      (clkEn && convDone && s_r.seq == safing_adc_pkg::SEQ_RESERVE)
      |=> s_r.reserveValid)
      else $error("reserve strobe missing after done");

   a_sample_latch: assert property (@(posedge clk) disable iff (!rstN_r)
      (clkEn && s_r.sensorValid) |=> (s_r.sample == $past(filtOut)))
      else $error("safing sample not latched from filter");

   a_discharge_set: assert property (@(posedge clk) disable iff (!rstN_r)
      (clkEn && frameFall && s_r.seq == safing_adc_pkg::SEQ_IDLE && s_r.testEnable)
      |=> s_r.discharge)
      else $error("discharge not asserted at sync fall");

   a_reserve_start: assert property (@(posedge clk) disable iff (!rstN_r)
      (clkEn && convDone && s_r.seq == safing_adc_pkg::SEQ_SAFING)
      |=> (s_r.inputSelect && s_r.convStart))
      else $error("reserve conversion not started after safing");

   a_discharge_off: assert property (@(posedge clk) disable iff (!rstN_r)
      s_r.reserveValid |-> !s_r.discharge)
      else $error("discharge still on after reserve conversion");

   a_diag_msbs: assert property (@(posedge clk) disable iff (!rstN_r)
      (clkEn && s_r.seq == safing_adc_pkg::SEQ_RESERVE && convDone)
      |=> (s_r.diag == $past(convData[9:2])))
      else $error("diagnostic does not hold upper result bits");

   a_suspend_blocks: assert property (@(posedge clk) disable iff (!rstN_r)
      (clkEn && convDone && s_r.seq == safing_adc_pkg::SEQ_SAFING && s_r.suspend)
      |=> !s_r.sensorValid)
      else $error("sensor strobe not blocked while suspended");

   a_suspend_cause: assert property (@(posedge clk) disable iff (!rstN_r)
      $rose(s_r.suspend) |-> $past(frameFall && s_r.stSync2))
      else $error("suspend set without high sample at sync fall");

   a_single_start: assert property (@(posedge clk) disable iff (!rstN_r)
      (clkEn && s_r.seq != safing_adc_pkg::SEQ_IDLE && !convDone) |=> !s_r.convStart)
      else $error("second start before done");

endmodule : safing_adc_sequencer

// >>> spi_host_model.sv
// host serial master stand-in: one task sends a whole 16-bit frame.
// assumes the slave shifts on falling and captures on rising clock edges.
`timescale 1ns/1ps

module spi_host_model (
   input  wire logic clk,
   input  wire logic so,
   output logic      csN,
   output logic      sck,
   output logic      si
);
   // idle: deselected, clock parked low
   initial begin
      csN = 1'b1;
      sck = 1'b0;
      si  = 1'b1;
   end

   // msb first, 160 ns serial period; so is taken late in the high phase
   // because the slave only moves it after a synchronised falling edge
   task automatic xfer(input logic [15:0] req, output logic [15:0] resp);
      @(negedge clk) csN = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 15; i >= 0; i--) begin
         si = req[i];
         repeat (4) @(negedge clk);
         sck = 1'b1;
         repeat (4) @(negedge clk);
         resp[i] = so;
         sck = 1'b0;
      end
      repeat (4) @(negedge clk);
      csN = 1'b1;
      si  = ~si; // released line shows no stale value
      repeat (8) @(negedge clk);
   endtask : xfer
endmodule : spi_host_model

// >>> safing_adc_sequencer_tb.sv
// bench for the safing converter sequencer: converter stand-in, host
// master model, and directed scenarios; assumes the package constants.
`timescale 1ns/1ps

module safing_adc_sequencer_tb;
   logic        clk, arst_n, frameSync, stPin, convStart, inputSelect;
   logic        reserveDischarge, reserveTestEnable, safingSuspend, csN, sck, si, so, soEn;
   logic        convDone = 1'b0;
   logic        clkEn    = 1'b1;
   logic [9:0]  convData = 10'h000;
   logic [2:0]  doneCnt  = 3'h0;
   logic [15:0] rsp;
   int          n_errors, num_checks;
   int          nStarts  = 0;
   localparam logic [9:0] RES_DATA = 10'h2d6;

   safing_adc_sequencer uut (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .frameSync(frameSync),
      .selftestRequestPin(stPin), .convDone(convDone), .convData(convData),
      .convStart(convStart), .inputSelect(inputSelect), .reserveDischarge(reserveDischarge),
      .reserveTestEnable(reserveTestEnable), .safingSuspend(safingSuspend),
      .csN(csN), .sck(sck), .si(si), .so(so), .soEn(soEn));
   spi_host_model host (.clk(clk), .so(so), .csN(csN), .sck(sck), .si(si));

   // ************************************************************************
   // clock and converter stand-in
   // ************************************************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // answers each start three cycles later; data toggles outside done
   always @(negedge clk) begin
      convDone <= 1'b0;
      convData <= ~convData;
      if (convStart) nStarts <= nStarts + 1;
      if (convStart) doneCnt <= 3'h3;
      else if (doneCnt != 3'h0) doneCnt <= doneCnt - 3'h1;
      if (doneCnt == 3'h1) begin
         convDone <= 1'b1;
         convData <= inputSelect ? RES_DATA : 10'h155;
      end
   end

   // ************************************************************************
   // shared tasks
   // ************************************************************************
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : stop_test

   task automatic waitStart;
      int i;
      for (i = 0; i < 20 && convStart !== 1'b1; i++) @(negedge clk);
      if (i == 20) begin
         chk("conversion start", convStart, 1'b1);
         stop_test();
      end
   endtask : waitStart

   // one sync fall and the two conversions behind it
   task automatic doSync(input logic st, input logic en);
      int n;
      n = nStarts;
      @(negedge clk) stPin = st;
      frameSync = 1'b0;
      waitStart();
      chk("discharge on", reserveDischarge, en);
      chk("select first", inputSelect, 1'b0);
      repeat (2) @(negedge clk);
      waitStart();
      chk("select second", inputSelect, 1'b1);
      repeat (6) @(negedge clk);
      chk("discharge off", reserveDischarge, 1'b0);
      chk("start count", 16'(nStarts - n), 16'h2);
      frameSync = 1'b1;
      repeat (5) @(negedge clk);
   endtask : doSync

   // ************************************************************************
   // scenarios
   // ************************************************************************
   task automatic testFrames;
      chk("so enable idle", soEn, 1'b0);
      host.xfer(16'h0100, rsp);
      chk("first reply", rsp, 16'h8100);
      doSync(1'b0, 1'b0);
      host.xfer(16'h200f, rsp);
      chk("test off ack", rsp, 16'h8000);
      host.xfer(16'he00f, rsp);
      chk("sample status", rsp[11:10], 2'h1);
      chk("sample parity", ^rsp, 1'b1);
      host.xfer(16'h0101, rsp);
      chk("reread status", {rsp[15:13], rsp[11:10], rsp[4]}, 6'h31);
      chk("reread parity", ^rsp, 1'b1);
      chk("test enable", reserveTestEnable, 1'b1);
      $display("frames test done");
   endtask : testFrames

   task automatic testDiag;
      doSync(1'b0, 1'b1);
      host.xfer(16'h0200, rsp);
      chk("test on ack", rsp, 16'h8001);
      host.xfer(16'h0200, rsp);
      chk("diag value", rsp, {8'h80, RES_DATA[9:2]});
      host.xfer(16'h0100, rsp);
      chk("diag cleared", rsp, 16'h8000);
      host.xfer(16'h2000, rsp);
      chk("test off ack", rsp, 16'h8000);
      chk("test off", reserveTestEnable, 1'b0);
      host.xfer(16'h1f00, rsp);
      chk("other channel", rsp, 16'h0008);
      host.xfer(16'h0200, rsp);
      chk("unknown request", rsp, 16'h8100);
      $display("diag test done");
   endtask : testDiag

   // a sync fall seen only while frozen must never start a conversion
   task automatic testFreeze;
      int n;
      n = nStarts;
      @(negedge clk) clkEn = 1'b0;
      frameSync = 1'b0;
      repeat (8) @(negedge clk);
      chk("frozen start", 16'(nStarts - n), 16'h0);
      frameSync = 1'b1;
      repeat (2) @(negedge clk);
      clkEn = 1'b1;
      repeat (8) @(negedge clk);
      chk("no late start", 16'(nStarts - n), 16'h0);
      $display("freeze test done");
   endtask : testFreeze

   task automatic testSuspend;
      for (int i = 1; i <= 3; i++) begin
         doSync(1'b1, 1'b0);
         chk("suspend set", safingSuspend, i == 3);
      end
      for (int i = 1; i <= 6; i++) begin
         doSync(1'b0, 1'b0);
         chk("suspend clear", safingSuspend, i < 6);
      end
      for (int i = 1; i <= 3; i++) doSync(1'b1, 1'b0);
      @(negedge clk) arst_n = 1'b0;
      repeat (2) @(negedge clk);
      chk("suspend reset", safingSuspend, 1'b0);
      arst_n = 1'b1;
      repeat (6) @(negedge clk);
      host.xfer(16'h0100, rsp);
      chk("reply after reset", rsp, 16'h8100);
      $display("suspend test done");
   endtask : testSuspend

   // reset for four cycles, then the scenarios in turn
   initial begin
      arst_n = 1'b0;
      frameSync = 1'b1;
      stPin = 1'b0;
      n_errors = 0;
      num_checks = 0;
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      repeat (6) @(negedge clk);
      testFrames();
      testDiag();
      testFreeze();
      testSuspend();
      stop_test();
   end
endmodule : safing_adc_sequencer_tb
